// ### logic/fsr_core.sv
`timescale 1ns/1ns
module fsr_core #(
	parameter int unsigned PROG_CYC = fsr_pkg::REC_PROG_US * fsr_pkg::NS_PER_US / fsr_pkg::CLK_NS,
	parameter int unsigned SE4K_CYC = fsr_pkg::REC_SE4K_MS * fsr_pkg::NS_PER_MS / fsr_pkg::CLK_NS,
	parameter int unsigned BE_CYC = fsr_pkg::REC_BE_MS * fsr_pkg::NS_PER_MS / fsr_pkg::CLK_NS,
	parameter int unsigned CE_CYC = fsr_pkg::REC_CE_MS * fsr_pkg::NS_PER_MS / fsr_pkg::CLK_NS,
	parameter int unsigned WRSR_CYC = fsr_pkg::REC_WRSR_MS * fsr_pkg::NS_PER_MS / fsr_pkg::CLK_NS
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire fsr_pkg::fsr_pins_t i_pins,
	input wire logic i_quad_mode,
	input wire logic i_perf_mode,
	input wire fsr_pkg::fsr_op_t i_op_kind,
	input wire logic i_erase_suspend,
	input wire logic i_program_suspend,
	input wire logic [7:0] i_table_byte,
	output logic o_so,
	output logic o_so_oe,
	output logic o_ready,
	output logic o_erase_paused_flag,
	output logic o_program_paused_flag,
	output logic o_write_latch_flag,
	output logic o_resume,
	output logic o_abort,
	output logic [fsr_pkg::ADDR_W-1:0] o_table_addr
);
	import fsr_pkg::*;

	logic rst_s;
	fsr_pins_t pins_s;
	fsr_pins_t pins_d_q;
	fsr_st_t st_q;
	logic [5:0] bit_cnt_q;
	logic [SR_W-1:0] sr_q;
	logic [2:0] out_idx_q;
	logic armed_q;
	fsr_op_t paused_op_q;
	logic [CLR_W-1:0] clr_cnt_q;
	logic [CNT_W-1:0] rec_cnt_q;
	logic in_rst_q;
	fsr_op_t rec_kind_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;
	logic [5:0] step;
	logic [5:0] nxt_cnt;
	logic [SR_W-1:0] sr_nxt;
	logic cmd_done;
	logic [7:0] opc;
	logic resume_ok;
	logic soft_rst;
	logic pin_hold;
	logic rec_load;
	fsr_op_t kind_now;

	// Serial shift: single-line mode reads only the lowest data line
	function automatic logic [SR_W-1:0] shift_in(input logic [SR_W-1:0] sr,
			input logic [3:0] sio, input logic quad);
		shift_in = quad ? {sr[SR_W-5:0], sio} : {sr[SR_W-2:0], sio[0]};
	endfunction : shift_in

	// Recovery length picked by what the reset interrupted
	function automatic logic [CNT_W-1:0] recov_cycles(input fsr_op_t k);
		case (k)
			OP_DECODE: recov_cycles = CNT_W'(REC_DECODE_CYC);
			OP_READ: recov_cycles = CNT_W'(REC_READ_CYC);
			OP_PROG: recov_cycles = CNT_W'(PROG_CYC);
			OP_SE4K: recov_cycles = CNT_W'(SE4K_CYC);
			OP_BE: recov_cycles = CNT_W'(BE_CYC);
			OP_CE: recov_cycles = CNT_W'(CE_CYC);
			OP_WRSR: recov_cycles = CNT_W'(WRSR_CYC);
			default: recov_cycles = CNT_W'(REC_POWERUP_CYC);
		endcase
	endfunction : recov_cycles

	// Reset release and pin synchronisers
	fsr_sync #(.W(1)) u_rst_sync (
		.i_clk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_d(1'b1),
		.o_q(rst_s)
	);

	fsr_sync #(.W($bits(fsr_pins_t)), .RST_VAL(PINS_IDLE)) u_pin_sync (
		.i_clk(i_mclk),
		.i_rst_n(rst_s),
		.i_d(i_pins),
		.o_q(pins_s)
	);

	// Previous synchronised pins for edge detection
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			pins_d_q <= PINS_IDLE;
		end else begin
			pins_d_q <= pins_s;
		end
	end

	// Edges of the sampled link clock and select
	assign sclk_rise = pins_s.sclk & ~pins_d_q.sclk;
	assign sclk_fall = ~pins_s.sclk & pins_d_q.sclk;
	assign cs_rise = pins_s.cs_n & ~pins_d_q.cs_n;
	assign step = i_quad_mode ? STEP_QUAD : STEP_SINGLE;
	assign nxt_cnt = (bit_cnt_q < BIT_SAT) ? bit_cnt_q + step : bit_cnt_q;
	assign sr_nxt = shift_in(sr_q, pins_s.sio, i_quad_mode);
	assign opc = sr_q[7:0];

	// Short opcodes act only when select rises exactly on the opcode boundary;
	// only pin and power-on resets veto here, the soft reset would close a loop
	assign cmd_done = cs_rise && st_q == ST_OPC && bit_cnt_q == OPC_BITS
		&& !pins_s.por_active && !pin_hold;
	assign resume_ok = cmd_done && opc == OPC_RESUME && !i_perf_mode;
	assign soft_rst = cmd_done && opc == OPC_RESET_EXEC && armed_q;

	// Pin reset counts only once held for the minimum pulse
	assign pin_hold = clr_cnt_q == CLR_W'(CLR_PULSE_CYC);
	assign rec_load = pins_s.por_active | pin_hold | soft_rst;

	// Erase pause overrides everything but power-on reset
	always_comb begin
		if (pins_s.por_active) begin
			kind_now = OP_IDLE;
		end else if (o_erase_paused_flag) begin
			kind_now = paused_op_q;
		end else if (i_op_kind != OP_IDLE) begin
			kind_now = i_op_kind;
		end else if (st_q == ST_DATA) begin
			kind_now = OP_READ;
		end else if (st_q != ST_IDLE && st_q != ST_SKIP) begin
			kind_now = OP_DECODE;
		end else begin
			kind_now = OP_IDLE;
		end
	end

	// Reset pin low-time counter, saturating at the minimum pulse
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			clr_cnt_q <= '0;
		end else if (pins_s.reset_n) begin
			clr_cnt_q <= '0;
		end else if (!pin_hold) begin
			clr_cnt_q <= clr_cnt_q + CLR_W'(1);
		end
	end

	// Recovery timer; a held reset keeps reloading so it counts from release
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			rec_cnt_q <= CNT_W'(REC_POWERUP_CYC);
			in_rst_q <= 1'b0;
			rec_kind_q <= OP_IDLE;
		end else begin
			in_rst_q <= rec_load;
			if (rec_load && !in_rst_q) begin
				rec_kind_q <= kind_now;
				rec_cnt_q <= recov_cycles(kind_now);
			end else if (rec_load) begin
				rec_cnt_q <= recov_cycles(pins_s.por_active ? OP_IDLE : rec_kind_q);
			end else if (rec_cnt_q != '0) begin
				rec_cnt_q <= rec_cnt_q - CNT_W'(1);
			end
		end
	end

	// Ready only after recovery, with no reset source active
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			o_ready <= 1'b0;
		end else begin
			o_ready <= rec_cnt_q == '0 && !rec_load && pins_s.reset_n;
		end
	end

	// Abort pulse to the write engine on any reset
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			o_abort <= 1'b0;
		end else begin
			o_abort <= rec_load && !in_rst_q;
		end
	end

	// Frame sequencer; frames that start while not ready are skipped whole
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			st_q <= ST_IDLE;
			bit_cnt_q <= '0;
			sr_q <= '0;
		end else if (rec_load || pins_s.cs_n) begin
			st_q <= ST_IDLE;
			bit_cnt_q <= '0;
		end else begin
			case (st_q)
				ST_IDLE: begin
					st_q <= o_ready ? ST_OPC : ST_SKIP;
					bit_cnt_q <= '0;
				end
				ST_OPC: begin
					if (sclk_rise) begin
						sr_q <= sr_nxt;
						bit_cnt_q <= nxt_cnt;
						if (nxt_cnt == OPC_BITS && sr_nxt[7:0] == OPC_PARAM_READ) begin
							st_q <= ST_ADDR;
						end
					end
				end
				ST_ADDR: begin
					if (sclk_rise) begin
						sr_q <= sr_nxt;
						bit_cnt_q <= nxt_cnt;
						if (nxt_cnt == ADDR_END) begin
							st_q <= ST_DUMMY;
						end
					end
				end
				ST_DUMMY: begin
					if (sclk_rise) begin
						bit_cnt_q <= nxt_cnt;
						if (nxt_cnt == DUMMY_END) begin
							st_q <= ST_DATA;
						end
					end
				end
				ST_DATA: st_q <= ST_DATA;
				default: st_q <= ST_SKIP;
			endcase
		end
	end

	// Table output shifts on falling link edges, address auto-increments
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			o_so <= 1'b0;
			o_so_oe <= 1'b0;
			out_idx_q <= '0;
			o_table_addr <= '0;
		end else if (!pins_s.reset_n || rec_load || st_q != ST_DATA) begin
			o_so_oe <= 1'b0;
			out_idx_q <= '0;
			if (st_q == ST_ADDR && sclk_rise && nxt_cnt == ADDR_END) begin
				o_table_addr <= sr_nxt[ADDR_W-1:0];
			end
		end else if (sclk_fall) begin
			o_so <= i_table_byte[3'h7 - out_idx_q];
			o_so_oe <= 1'b1;
			out_idx_q <= out_idx_q + 3'h1;
			if (out_idx_q == 3'h7) begin
				o_table_addr <= o_table_addr + ADDR_W'(1);
			end
		end
	end

	// Reset arm holds only until the very next command of any kind
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			armed_q <= 1'b0;
		end else if (rec_load) begin
			armed_q <= 1'b0;
		end else if (cmd_done && opc == OPC_NOP) begin
			armed_q <= 1'b0;
		end else if (cmd_done) begin
			armed_q <= opc == OPC_RESET_ARM;
		end else if (cs_rise && st_q != ST_IDLE && st_q != ST_SKIP) begin
			armed_q <= 1'b0;
		end
	end

	// Write latch: set by its command, cleared by every reset
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			o_write_latch_flag <= 1'b0;
		end else if (rec_load) begin
			o_write_latch_flag <= 1'b0;
		end else if (cmd_done && opc == OPC_LATCH_SET) begin
			o_write_latch_flag <= 1'b1;
		end
	end

	// Paused flags: a suspend in the resume cycle wins over the clear
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			o_erase_paused_flag <= 1'b0;
			o_program_paused_flag <= 1'b0;
			paused_op_q <= OP_IDLE;
		end else if (rec_load) begin
			o_erase_paused_flag <= 1'b0;
			o_program_paused_flag <= 1'b0;
		end else begin
			if (i_erase_suspend) begin
				o_erase_paused_flag <= 1'b1;
				paused_op_q <= i_op_kind;
			end else if (resume_ok) begin
				o_erase_paused_flag <= 1'b0;
			end
			if (i_program_suspend) begin
				o_program_paused_flag <= 1'b1;
			end else if (resume_ok) begin
				o_program_paused_flag <= 1'b0;
			end
		end
	end

	// Resume pulse to the write engine
	always_ff @(posedge i_mclk or negedge rst_s) begin
		if (!rst_s) begin
			o_resume <= 1'b0;
		end else begin
			o_resume <= resume_ok;
		end
	end

	a_resume_clears: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(resume_ok && !i_erase_suspend && !i_program_suspend)
		|=> !o_erase_paused_flag && !o_program_paused_flag)
		else $error("resume left a paused flag set");
	a_perf_blocks: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(cmd_done && opc == OPC_RESUME && i_perf_mode) |=> !o_resume)
		else $error("resume taken in performance mode");
	a_no_latch_resume: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(cmd_done && opc == OPC_RESUME && !i_perf_mode && !o_write_latch_flag) |=> o_resume)
		else $error("resume refused without latch");
	a_unarmed_reset: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(cmd_done && opc == OPC_RESET_EXEC && !armed_q && o_ready && !rec_load)
		|=> !o_abort ##1 o_ready)
		else $error("reset executed without arm");
	a_nop_disarm: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(cmd_done && opc == OPC_NOP) |=> !armed_q && $stable(o_write_latch_flag))
		else $error("no-op misbehaved");
	a_soft_recovery: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(soft_rst && !in_rst_q && kind_now == OP_DECODE)
		|=> rec_cnt_q == CNT_W'(REC_DECODE_CYC) ##1 !o_ready)
		else $error("decode recovery wrong");
	a_erase_recovery: assert property (@(posedge i_mclk) disable iff (!rst_s)
		(rec_load && !in_rst_q && !pins_s.por_active && o_erase_paused_flag
		&& paused_op_q == OP_SE4K) |=> rec_cnt_q == CNT_W'(SE4K_CYC))
		else $error("erase pause recovery wrong");
	a_pin_hiz: assert property (@(posedge i_mclk) disable iff (!rst_s)
		!pins_s.reset_n |=> !o_so_oe)
		else $error("output driven during pin reset");
	a_por_hold: assert property (@(posedge i_mclk) disable iff (!rst_s)
		pins_s.por_active |=> !o_ready && !o_write_latch_flag && !o_resume)
		else $error("logic active under power-on reset");
	c_resume: cover property (@(posedge i_mclk) disable iff (!rst_s) resume_ok);
	c_soft_reset: cover property (@(posedge i_mclk) disable iff (!rst_s) soft_rst);
	c_table_out: cover property (@(posedge i_mclk) disable iff (!rst_s)
		o_so_oe && out_idx_q == 3'h7);
	c_pin_reset: cover property (@(posedge i_mclk) disable iff (!rst_s) pin_hold);
endmodule : fsr_core

// ### logic/fsr_pkg.sv
// Overview of operation
// - Resume opcode in one framed command cycle
// - Accepted resume clears both paused flags
// - Resume needs no write latch set first
// - Resume ignored while performance mode is on
// - No-op only cancels a pending reset arm
// - Eight single-line or two quad clocks opcode
// - Reset executes only right after reset arm
// - Software reset restores standby and defaults
// - Software reset aborts program or erase
// - Decode reset 40us, read reset 35us recovery
// - Write reset recovery depends on operation kind
// - Table read: opcode, address, dummy, data out
// - Long low reset pin resets volatile state
// - Reset pin low floats output; long low aborts write
// - Soft or pin reset during erase pause uses erase recovery
// - Power-up gives standby with latch cleared
// - Power-on reset holds logic, ignores commands
// - Erase paused flag set on suspend, cleared on resume
package fsr_pkg;
	localparam int CLK_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int NS_PER_MS = 1000000;
	// Times as printed, cycle counts rounded up as minimums
	localparam int CLR_PULSE_MIN_US = 10;
	localparam int CLR_PULSE_CYC = (CLR_PULSE_MIN_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int REC_POWERUP_US = 35;
	localparam int REC_POWERUP_CYC = (REC_POWERUP_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int REC_DECODE_US = 40;
	localparam int REC_DECODE_CYC = (REC_DECODE_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int REC_READ_US = 35;
	localparam int REC_READ_CYC = (REC_READ_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
	localparam int REC_PROG_US = 310;
	localparam int REC_SE4K_MS = 12;
	localparam int REC_BE_MS = 25;
	localparam int REC_CE_MS = 100;
	localparam int REC_WRSR_MS = 40;
	localparam int CNT_W = 24;
	localparam int CLR_W = 11;
	// Command opcodes
	localparam logic [7:0] OPC_RESUME = 8'h30;
	localparam logic [7:0] OPC_NOP = 8'h00;
	localparam logic [7:0] OPC_RESET_ARM = 8'h66;
	localparam logic [7:0] OPC_RESET_EXEC = 8'h99;
	localparam logic [7:0] OPC_PARAM_READ = 8'h5A;
	localparam logic [7:0] OPC_LATCH_SET = 8'h06;
	// Frame bit positions
	localparam int SR_W = 32;
	localparam int ADDR_W = 24;
	localparam logic [5:0] OPC_BITS = 6'h08;
	localparam logic [5:0] ADDR_END = 6'h20;
	localparam logic [5:0] DUMMY_END = 6'h28;
	localparam logic [5:0] BIT_SAT = 6'h30;
	localparam logic [5:0] STEP_SINGLE = 6'h01;
	localparam logic [5:0] STEP_QUAD = 6'h04;
	typedef enum logic [2:0] {
		OP_IDLE = 3'b000,
		OP_DECODE = 3'b001,
		OP_READ = 3'b010,
		OP_PROG = 3'b011,
		OP_SE4K = 3'b100,
		OP_BE = 3'b101,
		OP_CE = 3'b110,
		OP_WRSR = 3'b111
	} fsr_op_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPC = 3'b001,
		ST_ADDR = 3'b010,
		ST_DUMMY = 3'b011,
		ST_DATA = 3'b100,
		ST_SKIP = 3'b101
	} fsr_st_t;
	typedef struct packed {
		logic por_active;
		logic reset_n;
		logic cs_n;
		logic sclk;
		logic [3:0] sio;
	} fsr_pins_t;
	// Link clock idles low, so the edge detector starts low and sees no false edge
	localparam fsr_pins_t PINS_IDLE = 8'h60;
endpackage : fsr_pkg

// ### logic/fsr_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser; the first stage feeds only the second
module fsr_sync #(
	parameter int W = 8,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_q;

	// Async reset loads constants only
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= RST_VAL;
			o_q <= RST_VAL;
		end else begin
			meta_q <= i_d;
			o_q <= meta_q;
		end
	end
endmodule : fsr_sync

// ### testbench/fsr_host.sv
`timescale 1ns/1ns
// Host flash controller model: frames commands, link clock idles low between frames
module fsr_host (
	input wire logic i_quad,
	input wire logic i_so,
	output logic o_cs_n,
	output logic o_sclk,
	output logic [3:0] o_sio
);
	import fsr_pkg::*;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b0;
		o_sio = 4'hA;
	end
	// One link clock period; lines change while the clock is low, data sampled at the rise
	task automatic unit(input logic [3:0] v, output logic s);
		o_sio = v;
		#62 o_sclk = 1'b1;
		s = i_so;
		#63 o_sclk = 1'b0;
	endtask : unit
	// MSB first; single-line mode puts noise on the unused upper lines
	task automatic shift(input logic [31:0] d, input int n);
		logic s;
		for (int i = n - 1; i >= 0; i -= (i_quad ? 4 : 1)) begin
			unit(i_quad ? d[i-:4] : {~d[i], d[i], ~d[i], d[i]}, s);
		end
	endtask : shift
	// Select, send, deselect; a released line shows the inverse of its last value
	task automatic frame(input logic [31:0] d, input int n);
		o_cs_n = 1'b0;
		#40 shift(d, n);
		#40 o_cs_n = 1'b1;
		o_sio = ~o_sio;
		#100;
	endtask : frame
	// Table read: opcode, address, one dummy byte, then n data bits
	task automatic read(input logic [23:0] a, input int n, output logic [31:0] q);
		logic s;
		q = '0;
		o_cs_n = 1'b0;
		#40 shift({24'h0, OPC_PARAM_READ}, 8);
		shift({8'h00, a}, 24);
		shift(32'h0, 8);
		for (int i = 0; i < n; i++) begin
			unit(~o_sio, s);
			q = {q[30:0], s};
		end
		#40 o_cs_n = 1'b1;
		o_sio = ~o_sio;
		#100;
	endtask : read
endmodule : fsr_host

// ### testbench/tb.sv
`timescale 1ns/1ns
module tb;
	import fsr_pkg::*;
	`define CHK(a, b) begin \
		total_checks++; \
		if ((a) !== (b)) begin \
			bad_count++; \
			$display("unexpected at %0t: got %0h expected %0h", $time, a, b); \
		end \
	end
	logic i_mclk, i_rst_n, por, pin_n, quad, perf, es, ps, loose;
	logic so, so_oe, rdy, efl, pfl, wlf, res, abt;
	logic [23:0] taddr, a;
	logic [7:0] tbyte, salt, b3;
	logic [31:0] st, got;
	logic [1:0] nt;
	logic [1:0] notes[$];
	fsr_op_t op;
	wire cs_n, sclk;
	wire [3:0] sio;
	fsr_pins_t pins;
	int bad_count, total_checks, n, lo;
	// Program recovery keeps its full default; the erase kinds are shortened
	int recs[8] = '{0, REC_DECODE_CYC, REC_READ_CYC, REC_PROG_US * NS_PER_US / CLK_NS,
		60, 70, 80, 90};
	assign pins = {por, pin_n, cs_n, sclk, sio};
	fsr_core #(.SE4K_CYC(60), .BE_CYC(70), .CE_CYC(80), .WRSR_CYC(90)) DUT (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_pins(pins), .i_quad_mode(quad),
		.i_perf_mode(perf), .i_op_kind(op), .i_erase_suspend(es), .i_program_suspend(ps),
		.i_table_byte(tbyte), .o_so(so), .o_so_oe(so_oe), .o_ready(rdy),
		.o_erase_paused_flag(efl), .o_program_paused_flag(pfl), .o_write_latch_flag(wlf),
		.o_resume(res), .o_abort(abt), .o_table_addr(taddr)
	);
	fsr_host H (.i_quad(quad), .i_so(so), .o_cs_n(cs_n), .o_sclk(sclk), .o_sio(sio));
	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end
	function automatic logic [31:0] xs();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction : xs
	function automatic logic [7:0] tab(input logic [23:0] x);
		return x[7:0] ^ x[23:16] ^ salt;
	endfunction : tab
	// Table contents follow the address the block asks for
	always @(negedge i_mclk) tbyte <= tab(taddr);
	// Length of the current not-ready stretch, in cycles
	always @(negedge i_mclk) lo <= rdy ? 0 : lo + 1;
	// Every pulse while loose is low takes the oldest note; a resume must find both paused flags clear
	always @(posedge i_mclk) begin
		if (!loose && (res || abt)) begin
			if (notes.size() == 0) begin
				bad_count++;
				$display("unexpected at %0t: pulse without a note", $time);
			end else begin
				nt = notes.pop_front();
				`CHK({res, abt}, nt)
			end
			if (res) `CHK({efl, pfl}, 2'b00)
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	task automatic idle(input int c);
		repeat (c) @(negedge i_mclk);
	endtask : idle
	// Bounded wait for ready to reach a level; n holds the cycles spent
	task automatic wready(input logic lvl);
		n = 0;
		while (rdy !== lvl) begin
			@(negedge i_mclk);
			n++;
			if (n > 40000) begin
				bad_count++;
				$display("unexpected at %0t: ready wait ran out", $time);
				results();
			end
		end
	endtask : wready
	task automatic sus(input logic e);
		@(negedge i_mclk);
		es = e;
		ps = !e;
		@(negedge i_mclk);
		es = 1'b0;
		ps = 1'b0;
		idle(2);
	endtask : sus
	initial begin
		st = 32'h0001362E;
		salt = 8'(xs());
		{i_rst_n, por, quad, perf, es, ps, loose} = '0;
		pin_n = 1'b1;
		op = OP_IDLE;
		idle(6);
		i_rst_n = 1'b1;
		wready(1'b1);
		`CHK(n >= REC_POWERUP_CYC, 1'b1)
		`CHK({efl, pfl, wlf, so_oe}, 4'h0)
		$display("test power_up done");
		sus(1'b1);
		`CHK(efl, 1'b1)
		perf = 1'b1;
		H.frame(32'(OPC_RESUME), 8);
		idle(20);
		`CHK(efl, 1'b1)
		perf = 1'b0;
		notes.push_back(2'b10);
		H.frame(32'(OPC_RESUME), 8);
		idle(20);
		`CHK(efl, 1'b0)
		idle(50);
		sus(1'b0);
		H.frame(32'(OPC_RESUME) >> 1, 7);
		idle(20);
		`CHK(pfl, 1'b1)
		quad = 1'b1;
		notes.push_back(2'b10);
		H.frame(32'(OPC_RESUME), 8);
		idle(20);
		`CHK(pfl, 1'b0)
		quad = 1'b0;
		$display("test resume done");
		H.frame(32'(OPC_LATCH_SET), 8);
		H.frame(32'(OPC_RESET_ARM), 8);
		H.frame(32'(OPC_NOP), 8);
		H.frame(32'(OPC_RESET_EXEC), 8);
		idle(20);
		`CHK({rdy, wlf}, 2'b11)
		for (int k = 1; k < 8; k++) begin
			@(negedge i_mclk) op = fsr_op_t'(k);
			H.frame(32'(OPC_LATCH_SET), 8);
			H.frame(32'(OPC_RESET_ARM), 8);
			notes.push_back(2'b01);
			H.frame(32'(OPC_RESET_EXEC), 8);
			wready(1'b0);
			wready(1'b1);
			`CHK(lo >= recs[k] && lo <= recs[k] + 6, 1'b1)
			`CHK(wlf, 1'b0)
		end
		$display("test software reset done");
		@(negedge i_mclk) op = OP_SE4K;
		H.frame(32'(OPC_LATCH_SET), 8);
		sus(1'b1);
		op = OP_PROG;
		pin_n = 1'b0;
		idle(300);
		pin_n = 1'b1;
		idle(20);
		`CHK({rdy, wlf, efl}, 3'b111)
		notes.push_back(2'b01);
		pin_n = 1'b0;
		idle(CLR_PULSE_CYC + 20);
		`CHK(so_oe, 1'b0)
		pin_n = 1'b1;
		wready(1'b1);
		`CHK(n >= recs[4] && n <= recs[4] + 8, 1'b1)
		`CHK({wlf, efl}, 2'b00)
		op = OP_IDLE;
		idle(CLR_PULSE_CYC);
		$display("test reset pin done");
		H.frame(32'(OPC_LATCH_SET), 8);
		idle(1);
		loose = 1'b1;
		por = 1'b1;
		idle(20);
		`CHK({rdy, wlf}, 2'b00)
		H.frame(32'(OPC_LATCH_SET), 8);
		idle(1);
		por = 1'b0;
		wready(1'b1);
		`CHK(n >= REC_POWERUP_CYC - 4 && wlf === 1'b0, 1'b1)
		loose = 1'b0;
		$display("test power-on reset done");
		a = 24'(xs());
		H.frame(32'(OPC_RESET_ARM), 8);
		H.read(a, 28, got);
		idle(10);
		`CHK(so_oe, 1'b0)
		b3 = tab(a + 24'h3);
		`CHK(got[27:0], {tab(a), tab(a + 24'h1), tab(a + 24'h2), b3[7:4]})
		H.frame(32'(OPC_RESET_EXEC), 8);
		idle(20);
		`CHK(rdy, 1'b1)
		`CHK(notes.size(), 0)
		$display("test table read done");
		results();
	end
endmodule : tb
